// ==== logic/core_exec.sv ====
// Four-phase instruction core: fetch, read-modify-write execution, branching and status
`timescale 1ns/10ps
`default_nettype none
// Functional notes
// - Each instruction is one 14-bit word split into an opcode and operand fields.
// - Every word is classed as a byte, bit, or literal and control operation.
// - Destination bit 0 sends the result to W and 1 writes it back to the file register.
// - The embedded file address spans 0x00 to 0x7F.
// - A 3-bit selector picks the bit of the 8-bit register that a bit operation uses.
// - Literal words carry an 8-bit data constant or an 11-bit jump or call target.
// - One instruction cycle lasts four oscillator periods.
// - A true skip or a program counter change costs a second cycle run as a no-op.
// - Every file register operation reads the register first, even a pure write.
// - Reading the second I/O port refreshes its change-detect reference, removing a pending change.
// - Don't-care opcode bits are accepted as either value.
// - Reading an I/O register for self-update samples the pins, not the output latch.
// - Writing the timer-zero count clears the shared prescaler when it belongs to the timer.
// - The literal add leaves W plus the 8-bit constant in W.
module core_exec
   import core_pkg::*;
#(
   parameter int STACK_DEPTH = 8
) (
   input  wire logic            sys_clk,
   input  wire logic            srst,
   input  wire logic [13:0]     instr_word,
   input  wire logic [7:0]      file_rdata,
   input  wire logic [7:0]      port_pins,
   input  wire logic            prescaler_to_timer,
   input  wire logic            wdt_timeout,
   output logic [PC_W-1:0]      pm_addr,
   output file_req_s            file_req,
   output logic [7:0]           w_reg,
   output logic                 timeout_flag,
   output logic                 powerdown_flag,
   output logic                 port_change_flag,
   output logic                 prescaler_clear,
   output logic                 instr_cycle_end
);

   localparam int SP_W = $clog2(STACK_DEPTH);

   if (STACK_DEPTH < 2 || (STACK_DEPTH & (STACK_DEPTH - 1)) != 0) begin : g_chk
      $error("STACK_DEPTH must be a power of two, at least 2");
   end

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   logic [1:0]            phase_q;
   logic [13:0]           ir_q;
   logic [PC_W-1:0]       pc_q;
   logic [7:0]            w_q;
   logic [7:0]            status_q;
   logic [7:0]            status_d;
   logic [7:0]            opa_q;
   logic [7:0]            port_ref_q;
   logic                  pchg_q;
   logic                  presc_q;
   logic                  cyc_end_q;
   file_req_s             freq_q;
   logic [PC_W-1:0]       stack_q [STACK_DEPTH];
   logic [SP_W-1:0]       sp_q;
   dec_s                  dec;
   logic [7:0]            result;
   logic                  cout;

   instr_decode u_dec (
      .instr (ir_q),
      .dec   (dec)
   );

   // ------------------------------------------------------------
   // Operand selection and adder
   // ------------------------------------------------------------
   wire              commit   = (phase_q == PH_LAST);
   wire              capture  = (phase_q == PH_READ);
   wire              rd_port  = (freq_q.addr == SECOND_IO_ADDR);
   wire              rd_stat  = (freq_q.addr == STATUS_ADDR);
   wire [7:0]        rd_mux   = rd_port ? port_pins : (rd_stat ? status_q : file_rdata);
   wire [7:0]        opa      = dec.use_lit ? dec.k8 : opa_q;
   wire [7:0]        bmask    = 8'h01 << dec.bsel;
   wire              bit_val  = |(opa & bmask);
   wire              is_sub   = (dec.alu == ALU_SUB);
   wire [7:0]        add_b    = is_sub ? ~w_q : w_q;
   wire [8:0]        sum9     = {1'b0, opa} + {1'b0, add_b} + {8'h00, is_sub};
   wire [4:0]        sum5     = {1'b0, opa[3:0]} + {1'b0, add_b[3:0]} + {4'h0, is_sub};
   wire              skip_tru = (dec.skip_zero && result == 8'h00) ||
                                (dec.skip_bclr && !bit_val) || (dec.skip_bset && bit_val);
   wire              two_cyc  = dec.jump || dec.ret || skip_tru;
   wire [SP_W-1:0]   sp_pop   = sp_q - 1'b1;
   wire [PC_W-1:0]   jump_pc  = {pc_q[PC_W-1:K11_W], dec.k11};
   wire [PC_W-1:0]   pc_next  = dec.jump ? jump_pc : (dec.ret ? stack_q[sp_pop] : pc_q + 13'h0001);
   wire              wr_timer = dec.wr_file && dec.faddr == TIMER_ZERO_ADDR;

   // Arithmetic and logic unit
   always_comb begin
      result = opa;
      cout   = status_q[ST_C];
      unique case (dec.alu)
         ALU_PASSA: result = opa;
         ALU_PASSW: result = w_q;
         ALU_ZERO:  result = 8'h00;
         ALU_ADD:   {cout, result} = sum9;
         ALU_SUB:   {cout, result} = sum9;         // Carry set means no borrow
         ALU_AND:   result = opa & w_q;
         ALU_IOR:   result = opa | w_q;
         ALU_XOR:   result = opa ^ w_q;
         ALU_COM:   result = ~opa;
         ALU_INC:   result = opa + 8'h01;
         ALU_DEC:   result = opa - 8'h01;
         ALU_RR:    {result, cout} = {status_q[ST_C], opa};
         ALU_RL:    {cout, result} = {opa, status_q[ST_C]};
         ALU_SWAP:  result = {opa[3:0], opa[7:4]};
         ALU_BCLR:  result = opa & ~bmask;
         ALU_BSET:  result = opa | bmask;
      endcase
   end

   // Status update; the watchdog event outranks any instruction touching timeout
   always_comb begin
      status_d = status_q;
      if (commit) begin
         if (dec.upd_z)  status_d[ST_Z]  = (result == 8'h00);
         if (dec.upd_c)  status_d[ST_C]  = cout;
         if (dec.upd_dc) status_d[ST_DC] = sum5[4];
         if (dec.wr_file && dec.faddr == STATUS_ADDR) status_d[2:0] = result[2:0];
         if (dec.sleep) begin
            status_d[ST_PD] = 1'b0;
            status_d[ST_TO] = 1'b1;
         end
         if (dec.clrwdt) begin
            status_d[ST_PD] = 1'b1;
            status_d[ST_TO] = 1'b1;
         end
      end
      if (wdt_timeout) status_d[ST_TO] = 1'b0;
      status_d[7:5] = 3'h0;
   end

   // ------------------------------------------------------------
   // Phase sequencer, fetch and execute
   // ------------------------------------------------------------
   // Fetch lands on the last phase; a two-cycle op drops the prefetched word
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         phase_q <= PH_FIRST;
         ir_q    <= NOP_WORD;
         pc_q    <= PC_RST;
      end else begin
         phase_q <= phase_q + 2'h1;
         if (commit) begin
            ir_q <= two_cyc ? NOP_WORD : instr_word;
            pc_q <= pc_next;
         end
      end
   end

   // Accumulator and status
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         w_q      <= 8'h00;
         status_q <= STATUS_RST;
      end else begin
         if (commit && dec.wr_w) w_q <= result;
         status_q <= status_d;
      end
   end

   // Return stack, wraps when overfilled
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         sp_q <= '0;
      end else if (commit && dec.call) begin
         stack_q[sp_q] <= pc_q;
         sp_q          <= sp_q + 1'b1;
      end else if (commit && dec.ret) begin
         sp_q <= sp_pop;
      end
   end

   // File bus: read in phase 1, write back on the phase after commit
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         freq_q <= '0;
         opa_q  <= 8'h00;
      end else begin
         if (phase_q == PH_FIRST) begin
            freq_q.addr <= dec.faddr;
            freq_q.rd   <= dec.rd_file;
            freq_q.wr   <= 1'b0;
         end
         if (capture) begin
            freq_q.rd <= 1'b0;
            opa_q     <= rd_mux;
         end
         if (commit) begin
            freq_q.wr    <= dec.wr_file;
            freq_q.wdata <= result;
         end
      end
   end

   // Port change detect; any port read re-arms the reference
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         port_ref_q <= PORT_REF_RST;
         pchg_q     <= 1'b0;
         presc_q    <= 1'b0;
         cyc_end_q  <= 1'b0;
      end else begin
         if (capture && freq_q.rd && rd_port) port_ref_q <= port_pins;
         pchg_q    <= (port_pins != port_ref_q);
         presc_q   <= commit && wr_timer && prescaler_to_timer;
         cyc_end_q <= commit;
      end
   end

   assign pm_addr          = pc_q;
   assign file_req         = freq_q;
   assign w_reg            = w_q;
   assign timeout_flag     = status_q[ST_TO];
   assign powerdown_flag   = status_q[ST_PD];
   assign port_change_flag = pchg_q;
   assign prescaler_clear  = presc_q;
   assign instr_cycle_end  = cyc_end_q;

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (srst);

   AST_CYCLE_FOUR: assert property (instr_cycle_end |=> !instr_cycle_end [*3] ##1 instr_cycle_end)
      else $error("instruction cycle is not four clocks");
   AST_TWO_CYCLE_NOP: assert property (commit && two_cyc |=> ir_q == NOP_WORD)
      else $error("two-cycle op did not insert a no-op");
   AST_REFETCH: assert property (commit && dec.jump |=> pm_addr == $past(jump_pc))
      else $error("jump did not refetch from the target");
   AST_READ_FIRST: assert property (file_req.wr |-> $past(file_req.rd, 3))
      else $error("file write without prior read");
   AST_DEST_W: assert property (commit && dec.wr_w |=> w_reg == $past(result) && !file_req.wr)
      else $error("W destination not honoured");
   AST_DEST_FILE: assert property (commit && dec.wr_file |=> file_req.wr && file_req.wdata == $past(result)
                                   && file_req.addr == $past(dec.faddr))
      else $error("file destination not honoured");
   AST_ADD_LIT: assert property (commit && dec.use_lit && dec.alu == ALU_ADD |=>
                                 w_reg == 8'($past(w_q) + $past(dec.k8)))
      else $error("literal add result wrong");
   AST_BIT_CLEAR: assert property (commit && dec.alu == ALU_BCLR |=>
                                   file_req.wdata == ($past(opa_q) & ~(8'h01 << $past(dec.bsel))))
      else $error("bit clear touched wrong bit");
   AST_PORT_REF: assert property (capture && file_req.rd && rd_port |=> port_ref_q == $past(port_pins))
      else $error("port read did not refresh reference");
   AST_PRESCALER: assert property (commit && wr_timer && prescaler_to_timer |=> prescaler_clear ##1 !prescaler_clear)
      else $error("prescaler clear missing");
   AST_SLEEP_FLAGS: assert property (commit && dec.sleep && !wdt_timeout |=> !powerdown_flag && timeout_flag)
      else $error("sleep flag update wrong");

   COV_CALL: cover property (commit && dec.call ##[4:200] commit && dec.ret);
   COV_SKIP: cover property (commit && skip_tru && !dec.jump);
   COV_PORT_CHANGE: cover property (port_change_flag ##1 capture && file_req.rd && rd_port);

endmodule // core_exec
`default_nettype wire

// ==== logic/core_pkg.sv ====
// Shared constants, enumerations and carrier structs for the instruction core
package core_pkg;

   // ------------------------------------------------------------
   // Widths and timing
   // ------------------------------------------------------------
   localparam int             INSTR_W  = 14;
   localparam int             DATA_W   = 8;
   localparam int             FADDR_W  = 7;
   localparam int             PC_W     = 13;
   localparam int             K11_W    = 11;
   localparam int             PHASES   = 4;          // Oscillator periods per instruction cycle
   localparam logic [1:0]     PH_FIRST = 2'h0;
   localparam logic [1:0]     PH_READ  = 2'h1;
   localparam logic [1:0]     PH_LAST  = 2'h3;

   // ------------------------------------------------------------
   // File map and status layout
   // ------------------------------------------------------------
   localparam logic [6:0]     FILE_ADDR_MIN    = 7'h00;
   localparam logic [6:0]     FILE_ADDR_MAX    = 7'h7F;
   localparam logic [6:0]     TIMER_ZERO_ADDR  = 7'h01;
   localparam logic [6:0]     STATUS_ADDR      = 7'h03;
   localparam logic [6:0]     SECOND_IO_ADDR   = 7'h06;
   localparam int             ST_C             = 0;
   localparam int             ST_DC            = 1;
   localparam int             ST_Z             = 2;
   localparam int             ST_PD            = 3;
   localparam int             ST_TO            = 4;
   localparam logic [7:0]     STATUS_RST       = 8'h18;  // Timeout and powerdown set after reset
   localparam logic [13:0]    NOP_WORD         = 14'h0000;
   localparam logic [12:0]    PC_RST           = 13'h0000;
   localparam logic [7:0]     PORT_REF_RST     = 8'h00;

   // ------------------------------------------------------------
   // Types
   // ------------------------------------------------------------
   typedef enum logic [1:0] {GRP_BYTE, GRP_BIT, GRP_CTRL, GRP_LIT} group_e;

   typedef enum logic [3:0] {
      ALU_PASSA, ALU_PASSW, ALU_ZERO, ALU_ADD, ALU_SUB, ALU_AND, ALU_IOR, ALU_XOR,
      ALU_COM, ALU_INC, ALU_DEC, ALU_RR, ALU_RL, ALU_SWAP, ALU_BCLR, ALU_BSET
   } alu_e;

   typedef struct packed {
      group_e            grp;
      alu_e              alu;
      logic              use_lit;
      logic              rd_file;
      logic              wr_file;
      logic              wr_w;
      logic [6:0]        faddr;
      logic [2:0]        bsel;
      logic [7:0]        k8;
      logic [10:0]       k11;
      logic              upd_z;
      logic              upd_c;
      logic              upd_dc;
      logic              skip_zero;
      logic              skip_bclr;
      logic              skip_bset;
      logic              jump;
      logic              call;
      logic              ret;
      logic              sleep;
      logic              clrwdt;
   } dec_s;

   typedef struct packed {
      logic [6:0]        addr;
      logic              rd;
      logic              wr;
      logic [7:0]        wdata;
   } file_req_s;

endpackage

// ==== logic/instr_decode.sv ====
// Instruction word decoder: splits a word into group, operation and operand fields
`timescale 1ns/10ps
`default_nettype none
module instr_decode
   import core_pkg::*;
(
   input  wire logic [13:0] instr,
   output dec_s             dec
);

   // ------------------------------------------------------------
   // Field split and group decode
   // ------------------------------------------------------------
   // Don't-care opcode bits are wildcards so either value decodes alike
   always_comb begin
      dec         = '0;
      dec.alu     = ALU_PASSA;
      dec.faddr   = instr[6:0];
      dec.bsel    = instr[9:7];
      dec.k8      = instr[7:0];
      dec.k11     = instr[10:0];
      unique case (instr[13:12])
         2'b00: begin
            dec.grp     = GRP_BYTE;
            dec.rd_file = 1'b1;
            dec.wr_file = instr[7];
            dec.wr_w    = ~instr[7];
            dec.upd_z   = 1'b1;
            unique case (instr[11:8])
               4'h0: begin
                  if (instr[7]) begin
                     dec.alu   = ALU_PASSW;
                     dec.upd_z = 1'b0;
                  end else begin
                     dec.grp     = GRP_CTRL;
                     dec.rd_file = 1'b0;
                     dec.wr_w    = 1'b0;
                     dec.upd_z   = 1'b0;
                     casez (instr[6:0])
                        7'b000_1000: dec.ret    = 1'b1;
                        7'b000_1001: dec.ret    = 1'b1;
                        7'b110_0011: dec.sleep  = 1'b1;
                        7'b110_0100: dec.clrwdt = 1'b1;
                        default:     dec.grp    = GRP_CTRL;
                     endcase
                  end
               end
               4'h1: begin
                  dec.alu     = ALU_ZERO;
                  dec.rd_file = instr[7];
               end
               4'h2: begin
                  dec.alu    = ALU_SUB;
                  dec.upd_c  = 1'b1;
                  dec.upd_dc = 1'b1;
               end
               4'h3: dec.alu = ALU_DEC;
               4'h4: dec.alu = ALU_IOR;
               4'h5: dec.alu = ALU_AND;
               4'h6: dec.alu = ALU_XOR;
               4'h7: begin
                  dec.alu    = ALU_ADD;
                  dec.upd_c  = 1'b1;
                  dec.upd_dc = 1'b1;
               end
               4'h8: dec.alu = ALU_PASSA;
               4'h9: dec.alu = ALU_COM;
               4'hA: dec.alu = ALU_INC;
               4'hB: begin
                  dec.alu       = ALU_DEC;
                  dec.upd_z     = 1'b0;
                  dec.skip_zero = 1'b1;
               end
               4'hC: begin
                  dec.alu   = ALU_RR;
                  dec.upd_z = 1'b0;
                  dec.upd_c = 1'b1;
               end
               4'hD: begin
                  dec.alu   = ALU_RL;
                  dec.upd_z = 1'b0;
                  dec.upd_c = 1'b1;
               end
               4'hE: begin
                  dec.alu   = ALU_SWAP;
                  dec.upd_z = 1'b0;
               end
               4'hF: begin
                  dec.alu       = ALU_INC;
                  dec.upd_z     = 1'b0;
                  dec.skip_zero = 1'b1;
               end
            endcase
         end
         2'b01: begin
            dec.grp     = GRP_BIT;
            dec.rd_file = 1'b1;
            unique case (instr[11:10])
               2'b00: begin
                  dec.alu     = ALU_BCLR;
                  dec.wr_file = 1'b1;
               end
               2'b01: begin
                  dec.alu     = ALU_BSET;
                  dec.wr_file = 1'b1;
               end
               2'b10: dec.skip_bclr = 1'b1;
               2'b11: dec.skip_bset = 1'b1;
            endcase
         end
         2'b10: begin
            dec.grp  = GRP_CTRL;
            dec.jump = 1'b1;
            dec.call = ~instr[11];
         end
         2'b11: begin
            dec.grp     = GRP_LIT;
            dec.use_lit = 1'b1;
            dec.wr_w    = 1'b1;
            casez (instr[11:8])
               4'b00??: dec.alu = ALU_PASSA;
               4'b01??: dec.ret = 1'b1;
               4'b1000: begin
                  dec.alu   = ALU_IOR;
                  dec.upd_z = 1'b1;
               end
               4'b1001: begin
                  dec.alu   = ALU_AND;
                  dec.upd_z = 1'b1;
               end
               4'b1010: begin
                  dec.alu   = ALU_XOR;
                  dec.upd_z = 1'b1;
               end
               4'b110?: begin
                  dec.alu    = ALU_SUB;
                  dec.upd_z  = 1'b1;
                  dec.upd_c  = 1'b1;
                  dec.upd_dc = 1'b1;
               end
               4'b111?: begin
                  dec.alu    = ALU_ADD;
                  dec.upd_z  = 1'b1;
                  dec.upd_c  = 1'b1;
                  dec.upd_dc = 1'b1;
               end
               default: dec.wr_w = 1'b0;               // Unassigned literal code runs as no-op
            endcase
         end
      endcase
   end

endmodule // instr_decode
`default_nettype wire

// ==== tb/tb_mcu_instruction_decode_exec.sv ====
// Self-checking bench for the four-phase instruction core
`timescale 1ns/10ps
`default_nettype none
module tb_mcu_instruction_decode_exec import core_pkg::*; ;
   // ------------------------------------------------------------
   // Signals, program and file memories
   // ------------------------------------------------------------
   logic            sys_clk;
   logic            srst;
   logic [13:0]     instr_word;
   logic [7:0]      file_rdata;
   logic [7:0]      port_pins;
   logic            prescaler_to_timer;
   logic            wdt_timeout;
   logic [PC_W-1:0] pm_addr;
   file_req_s       file_req;
   logic [7:0]      w_reg;
   logic            timeout_flag;
   logic            powerdown_flag;
   logic            port_change_flag;
   logic            prescaler_clear;
   logic            instr_cycle_end;
   logic [13:0]     rom [0:31];
   logic [7:0]      fmem [0:127];
   logic [6:0]      rd_addr;
   int              err_count;
   int              checks;
   int              n_end;
   int              n_clr;

   core_exec #(.STACK_DEPTH(8)) u_core_exec (
      .sys_clk(sys_clk), .srst(srst), .instr_word(instr_word), .file_rdata(file_rdata),
      .port_pins(port_pins), .prescaler_to_timer(prescaler_to_timer), .wdt_timeout(wdt_timeout),
      .pm_addr(pm_addr), .file_req(file_req), .w_reg(w_reg), .timeout_flag(timeout_flag),
      .powerdown_flag(powerdown_flag), .port_change_flag(port_change_flag),
      .prescaler_clear(prescaler_clear), .instr_cycle_end(instr_cycle_end));

   initial begin
      sys_clk = 1'b0;
      forever #2.5 sys_clk = ~sys_clk;
   end

   // Combinational memories, answered a fixed delay after each edge
   always @(posedge sys_clk) begin
      #1;
      instr_word = rom[pm_addr[4:0]];
      file_rdata = fmem[file_req.addr];
   end

   // ------------------------------------------------------------
   // Shared tasks
   // ------------------------------------------------------------
   task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
      checks++;
      if (got !== exp) begin
         err_count++;
         $display("mismatch %s expected %h seen %h", name, exp, got);
      end
   endtask

   // Reset held 12 cycles; file memory cleared so no stale result can pass
   task automatic start();
      srst = 1'b1;
      fmem = '{default: 8'h00};
      repeat (12) @(posedge sys_clk);
      #1;
      srst = 1'b0;
      n_end = 0;
      n_clr = 0;
   endtask

   // Write port and pulse counters live here so one process owns the memory and counts;
   // case equality so unknowns never count, and no stale write can land during a reset
   task automatic run(input int k);
      repeat (4 * k) begin
         @(posedge sys_clk);
         if (file_req.wr === 1'b1) fmem[file_req.addr] = file_req.wdata;
         if (file_req.rd === 1'b1) rd_addr = file_req.addr;
         if (prescaler_clear === 1'b1) n_clr++;
         if (instr_cycle_end === 1'b1) n_end++;
      end
      #1;
   endtask

   task automatic final_report();
      $display("checks %0d err_count %0d", checks, err_count);
      if (err_count == 0 && checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   // Literal moves and adds with don't-care bits set either way
   task automatic t_literal();
      rom = '{default: NOP_WORD};
      rom[0] = 14'h3125;
      rom[1] = 14'h3E10;
      rom[2] = 14'h3F01;
      start();
      run(2);
      n_end = 0;
      run(10);
      chk("cycle_ends", 8'h0A, n_end[7:0]);
      chk("w_literal", 8'h36, w_reg);
   endtask

   // Destination select, and a read before the clearing write to the top address
   task automatic t_byte();
      rom = '{default: NOP_WORD};
      rom[0] = 14'h3025;
      rom[1] = 14'h00A0;
      rom[2] = 14'h0720;
      rom[3] = 14'h07A0;
      rom[4] = 14'h01FF;
      start();
      fmem[127] = 8'h99;
      run(8);
      chk("w_dest0", 8'h4A, w_reg);
      chk("f20_dest1", 8'h6F, fmem[32]);
      chk("f7f_clr", 8'h00, fmem[127]);
      chk("rd_addr", 8'h7F, {1'b0, rd_addr});
   endtask

   // Bit set and bit clear hit only the selected bit
   task automatic t_bit();
      rom = '{default: NOP_WORD};
      rom[0] = 14'h16A1;
      rom[1] = 14'h1022;
      start();
      fmem[34] = 8'hFF;
      run(5);
      chk("bsf_bit5", 8'h20, fmem[33]);
      chk("bcf_bit0", 8'hFE, fmem[34]);
   endtask

   // Prefetched words after a jump or a true skip never execute
   task automatic t_branch();
      rom = '{default: NOP_WORD};
      rom[0] = 14'h2810;
      rom[1] = 14'h30AA;
      rom[16] = 14'h3055;
      rom[17] = 14'h1C23;
      rom[18] = 14'h3077;
      rom[19] = 14'h3E01;
      rom[20] = 14'h2018;
      rom[21] = 14'h3E01;
      rom[24] = 14'h3402;
      start();
      fmem[35] = 8'h01;
      run(9);
      chk("w_branch", 8'h56, w_reg);
      run(4);
      chk("w_call_ret", 8'h03, w_reg);
   endtask

   // Port reads take the pins and refresh the change reference
   task automatic t_port();
      rom = '{default: NOP_WORD};
      rom[0] = 14'h0806;
      rom[6] = 14'h0186;
      port_pins = 8'h5A;
      start();
      fmem[6] = 8'h11;
      run(1);
      chk("chg_set", 8'h01, {7'h0, port_change_flag});
      run(2);
      chk("w_pins", 8'h5A, w_reg);
      chk("chg_movf", 8'h00, {7'h0, port_change_flag});
      port_pins = 8'h3C;
      run(1);
      chk("chg_again", 8'h01, {7'h0, port_change_flag});
      run(7);
      chk("chg_clrf", 8'h00, {7'h0, port_change_flag});
      chk("port_clr", 8'h00, fmem[6]);
   endtask

   // Timer write clears the prescaler; sleep, watchdog and clear flags
   task automatic t_flags();
      rom = '{default: NOP_WORD};
      rom[0] = 14'h0081;
      rom[1] = 14'h0063;
      rom[8] = 14'h0064;
      rom[9] = 14'h0181;
      prescaler_to_timer = 1'b1;
      start();
      run(4);
      chk("psc_clear", 8'h01, n_clr[7:0]);
      chk("pd_sleep", 8'h00, {7'h0, powerdown_flag});
      chk("to_sleep", 8'h01, {7'h0, timeout_flag});
      // Watchdog event is a one-clock pulse; the later timer write runs unassigned
      wdt_timeout = 1'b1;
      @(posedge sys_clk);
      #1;
      wdt_timeout = 1'b0;
      prescaler_to_timer = 1'b0;
      run(1);
      chk("to_wdt", 8'h00, {7'h0, timeout_flag});
      run(7);
      chk("clrwdt", 8'h03, {6'h0, timeout_flag, powerdown_flag});
      chk("psc_kept", 8'h01, n_clr[7:0]);
   endtask

   initial begin
      srst = 1'b1;
      port_pins = 8'h00;
      prescaler_to_timer = 1'b0;
      wdt_timeout = 1'b0;
      err_count = 0;
      checks = 0;
      t_literal();
      t_byte();
      t_bit();
      t_branch();
      t_port();
      t_flags();
      final_report();
   end

   // Watchdog: the whole run needs well under 5 us
   initial begin
      #20000;
      err_count++;
      $display("mismatch watchdog expected done seen hang");
      final_report();
   end
endmodule // tb_mcu_instruction_decode_exec
`default_nettype wire
